// ### design/sps_consts.svh
// Constants for the suspend pad state controller.
// Assumes inclusion by design files that need config bit positions.
`ifndef SPS_CONSTS_SVH
`define SPS_CONSTS_SVH
// Config register 1E bit positions
`define SPS_R1E_CTRL_BIT 0
`define SPS_R1E_CSEL_LO 1
`define SPS_R1E_CSEL_HI 2
`define SPS_R1E_MEM_BIT 3
`define SPS_R1E_ENA_LO 6
`define SPS_R1E_ENA_HI 7
// Config register 0E bit position
`define SPS_R0E_GFX_BIT 0
// Card buffer enable field encodings (bits 7:6)
`define SPS_ENA_SUSP_TRI 2'h3
`define SPS_ENA_ALWAYS 2'h2
// Card chip select suspend codes (bits 2:1)
`define SPS_CSEL_LOW 2'h0
`define SPS_CSEL_HIGH 2'h1
`define SPS_CSEL_REL 2'h3
// Reset value of the tod tick counter
`define SPS_TOD_RESET 16'h0000
`endif

// ### design/sps_pkg.sv
// Types for the suspend pad state controller.
// Assumes sps_consts.svh is on the include path.
package sps_pkg;
  typedef enum logic [1:0] {
    SPS_RUN = 2'b00,
    SPS_SUSP = 2'b01
  } sps_mode_e;
  typedef logic [7:0] sps_config_register_t;
endpackage

// ### design/sps_pin_hold.sv
// One group of pad cells: functional, forced or released.
// Assumes caller computes force and release terms per group.
module sps_pin_hold #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Control
  input wire logic force_en,
  input wire logic [W-1:0] force_val,
  input wire logic release_en,
  // Functional source
  input wire logic [W-1:0] func_val,
  input wire logic func_oe,
  // Pads
  output logic [W-1:0] pad_o,
  output logic pad_oe
);
  typedef struct packed {
    logic [W-1:0] o;
    logic oe;
  } sps_hold_s;
  sps_hold_s st_reg;
  sps_hold_s st_next;
  always_comb begin
    st_next.o = force_en ? force_val : func_val;
    st_next.oe = release_en ? 1'b0 : (force_en ? 1'b1 : func_oe);
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign pad_o = st_reg.o;
  assign pad_oe = st_reg.oe;
endmodule // sps_pin_hold

// ### design/sps_suspend_pads.sv
// Suspend pad state controller: picks each pin group's suspend level.
// Assumes suspend and config bits come from logic on clk.
`include "sps_consts.svh"
module sps_suspend_pads #(
  parameter int LANES = 2,
  parameter int DACKS = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Suspend and configuration
  input wire logic suspend,
  input wire sps_pkg::sps_config_register_t config_register_1e,
  input wire sps_pkg::sps_config_register_t config_register_0e,
  input wire logic [1:0] card_sel_active_high,
  // Time-of-day clock pin
  input wire logic tod_clock_in,
  // Functional sources
  input wire logic [LANES-1:0] byte_lane_func_n,
  input wire logic [1:0] card_sel_func_n,
  input wire logic vsync_func,
  input wire logic [DACKS-1:0] dma_ack_func_n,
  input wire logic [1:0] card_buf_func_n,
  input wire logic card_dir_func,
  input wire logic card_refresh_func_n,
  input wire logic card_attr_func_n,
  // Pads
  output logic [LANES-1:0] byte_lane_select_n,
  output logic byte_lane_oe,
  output logic [1:0] card_chip_select_n,
  output logic card_chip_select_oe,
  output logic card_upper_select_n,
  output logic card_upper_select_oe,
  output logic vsync_first_line,
  output logic vsync_first_line_oe,
  output logic [DACKS-1:0] dma_ack_n,
  output logic dma_ack_oe,
  output logic [1:0] card_buffer_enable_n,
  output logic card_buffer_enable_oe,
  output logic card_buffer_dir,
  output logic card_refresh_n,
  output logic card_attr_select_n,
  output logic card_ctl_oe,
  // Status
  output logic [15:0] tod_ticks
);
  import sps_pkg::*;

  typedef struct packed {
    logic tod_s1;
    logic tod_s2;
    logic tod_d;
    logic [15:0] ticks;
    logic vs_hold;
  } sps_state_s;

  sps_state_s st_reg;
  sps_state_s st_next;

  // Inactive level of a pin whose asserted sense is given
  function automatic logic inactive_lvl(input logic active_high);
    return !active_high;
  endfunction

  logic susp;
  logic mem_drive;
  logic gfx_release;
  logic [1:0] csel;
  logic [1:0] ena_fld;
  logic ctl_low;
  logic [1:0] card_inact;
  logic [1:0] card_force;
  logic csel_release;

  assign susp = suspend;
  assign mem_drive = !config_register_1e[`SPS_R1E_MEM_BIT];
  assign gfx_release = config_register_0e[`SPS_R0E_GFX_BIT];
  assign csel = config_register_1e[`SPS_R1E_CSEL_HI:`SPS_R1E_CSEL_LO];
  assign ena_fld = config_register_1e[`SPS_R1E_ENA_HI:`SPS_R1E_ENA_LO];
  assign ctl_low = config_register_1e[`SPS_R1E_ENA_HI];
  assign card_inact = {inactive_lvl(card_sel_active_high[1]),
    inactive_lvl(card_sel_active_high[0])};
  // Code 3 releases; 0 low, 1 high, 2 inactive per polarity
  assign csel_release = susp && (csel == `SPS_CSEL_REL);
  always_comb begin
    if (csel == `SPS_CSEL_LOW) begin
      card_force = 2'b00;
    end else if (csel == `SPS_CSEL_HIGH) begin
      card_force = 2'b11;
    end else begin
      card_force = card_inact;
    end
  end

  // Time-of-day tick counter never gated by suspend
  always_comb begin
    st_next = st_reg;
    st_next.tod_s1 = tod_clock_in;
    st_next.tod_s2 = st_reg.tod_s1;
    st_next.tod_d = st_reg.tod_s2;
    if (st_reg.tod_s2 && !st_reg.tod_d) begin
      st_next.ticks = st_reg.ticks + 16'h0001;
    end
    // Vsync level frozen at the last cycle before suspend is entered
    if (!susp) begin
      st_next.vs_hold = vsync_func;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign tod_ticks = st_reg.ticks;

  sps_pin_hold #(.W(LANES)) u_lane (
    .clk(clk), .reset_n(reset_n),
    .force_en(susp),
    .force_val({LANES{1'b1}}),
    .release_en(susp && !mem_drive),
    .func_val(byte_lane_func_n), .func_oe(1'b1),
    .pad_o(byte_lane_select_n), .pad_oe(byte_lane_oe)
  );

  sps_pin_hold #(.W(2)) u_csel (
    .clk(clk), .reset_n(reset_n),
    .force_en(susp), .force_val(card_force),
    .release_en(csel_release),
    .func_val(card_sel_func_n), .func_oe(1'b1),
    .pad_o(card_chip_select_n), .pad_oe(card_chip_select_oe)
  );

  // First-generation upper select: only inactive or released
  sps_pin_hold #(.W(1)) u_upper (
    .clk(clk), .reset_n(reset_n),
    .force_en(susp), .force_val(card_inact[1]),
    .release_en(susp && csel[1]),
    .func_val(card_sel_func_n[1]), .func_oe(1'b1),
    .pad_o(card_upper_select_n), .pad_oe(card_upper_select_oe)
  );

  sps_pin_hold #(.W(1)) u_vs (
    .clk(clk), .reset_n(reset_n),
    .force_en(susp), .force_val(st_reg.vs_hold),
    .release_en(susp && gfx_release),
    .func_val(vsync_func), .func_oe(1'b1),
    .pad_o(vsync_first_line), .pad_oe(vsync_first_line_oe)
  );

  sps_pin_hold #(.W(DACKS)) u_dack (
    .clk(clk), .reset_n(reset_n),
    .force_en(1'b0), .force_val({DACKS{1'b1}}),
    .release_en(susp),
    .func_val(dma_ack_func_n), .func_oe(1'b1),
    .pad_o(dma_ack_n), .pad_oe(dma_ack_oe)
  );

  // Field 0x releases outside suspend too
  sps_pin_hold #(.W(2)) u_ena (
    .clk(clk), .reset_n(reset_n),
    .force_en(1'b0), .force_val(2'b11),
    .release_en(!ena_fld[1] || (susp && ena_fld[0])),
    .func_val(card_buf_func_n), .func_oe(1'b1),
    .pad_o(card_buffer_enable_n), .pad_oe(card_buffer_enable_oe)
  );

  // Without bit 7, controls go inactive or released with the memory bit
  sps_pin_hold #(.W(3)) u_ctl (
    .clk(clk), .reset_n(reset_n),
    .force_en(susp),
    .force_val(ctl_low ? 3'h0 : 3'h3),
    .release_en(susp && !ctl_low && !mem_drive),
    .func_val({card_dir_func, card_refresh_func_n, card_attr_func_n}),
    .func_oe(1'b1),
    .pad_o({card_buffer_dir, card_refresh_n, card_attr_select_n}),
    .pad_oe(card_ctl_oe)
  );

  dack_rel_a: assert property (@(posedge clk)
    disable iff (!reset_n) susp |=> !dma_ack_oe)
    else $error("dma ack driven in suspend");
  lane_inact_a: assert property (@(posedge clk)
    disable iff (!reset_n)
    susp && mem_drive |=> byte_lane_oe && &byte_lane_select_n)
    else $error("byte lane not inactive");
  csel_tri_a: assert property (@(posedge clk)
    disable iff (!reset_n)
    susp && csel == `SPS_CSEL_REL |=> !card_chip_select_oe)
    else $error("card select not released");
  csel_high_a: assert property (@(posedge clk)
    disable iff (!reset_n) susp && csel == `SPS_CSEL_HIGH
    |=> card_chip_select_oe && &card_chip_select_n)
    else $error("card select not high");
  ena_off_a: assert property (@(posedge clk)
    disable iff (!reset_n)
    !ena_fld[1] |=> !card_buffer_enable_oe)
    else $error("buffer enable driven");
  ena_drv_a: assert property (@(posedge clk)
    disable iff (!reset_n)
    ena_fld == `SPS_ENA_ALWAYS |=> card_buffer_enable_oe)
    else $error("buffer enable not driven");
  ctl_low_a: assert property (@(posedge clk)
    disable iff (!reset_n)
    susp && ctl_low |=> card_ctl_oe && !card_buffer_dir
    && !card_refresh_n && !card_attr_select_n)
    else $error("card controls not low");
  vs_hold_a: assert property (@(posedge clk)
    disable iff (!reset_n)
    susp && $past(susp) && !gfx_release |=> $stable(vsync_first_line))
    else $error("vsync toggled in suspend");
  vs_rel_a: assert property (@(posedge clk)
    disable iff (!reset_n)
    susp && gfx_release |=> !vsync_first_line_oe)
    else $error("vsync driven when released");
  run_back_a: assert property (@(posedge clk)
    disable iff (!reset_n)
    !susp |=> dma_ack_oe && dma_ack_n == $past(dma_ack_func_n))
    else $error("no functional drive");
  upper_a: assert property (@(posedge clk)
    disable iff (!reset_n)
    susp && !csel[1] |=> card_upper_select_n == $past(card_inact[1]))
    else $error("upper select not inactive");
endmodule // sps_suspend_pads

// ### testbench/sps_far_side.sv
// Far side of the pads: cards and the bus see resolved wire levels.
// Assumes pads and enables come straight from the controller.
module sps_far_side (
  // Clock
  input wire logic clk,
  // Pads
  input wire logic [1:0] sel_pad,
  input wire logic sel_oe,
  input wire logic [3:0] ack_pad,
  input wire logic ack_oe,
  // Wire levels
  output logic [1:0] sel_wire,
  output logic [3:0] ack_wire
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] last_reg;
  always_ff @(posedge clk) begin
    if (sel_oe) begin
      last_reg <= sel_pad;
    end
  end
  // A floating select shows the inverse, so a stale level never matches
  assign sel_wire = sel_oe ? sel_pad : ~last_reg;
  // Acknowledges have board pull-downs
  assign ack_wire = ack_oe ? ack_pad : 4'h0;
endmodule // sps_far_side

// ### testbench/sps_suspend_pads_test.sv
// Bench for the suspend pad controller: table of modes, then hand cases.
// Assumes pads answer one clock after their inputs.
module sps_suspend_pads_test;
  timeunit 1ns;
  timeprecision 1ns;
  import sps_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic suspend = 1'b0;
  logic tod = 1'b0;
  logic vs_func = 1'b0;
  logic [1:0] pol = 2'h0;
  logic [6:0] fv = 7'h00;
  sps_config_register_t r1e = 8'h00;
  sps_config_register_t r0e = 8'h00;
  logic [1:0] lane_n, sel_n, ena_n, sel_w, c;
  logic lane_oe, sel_oe, up_n, up_oe, vs, vs_oe, ack_oe, ena_oe;
  logic dir, rfsh_n, attr_n, ctl_oe;
  logic [3:0] ack_n, ack_w;
  logic [15:0] ticks, n;
  int num_errors = 0;
  int total_checks = 0;
  logic [10:0] rows [12] = '{{1'b0, 8'h80, 2'h0}, {1'b0, 8'h0e, 2'h1},
    {1'b1, 8'h00, 2'h0}, {1'b1, 8'h02, 2'h3}, {1'b1, 8'h04, 2'h0},
    {1'b1, 8'h04, 2'h2}, {1'b1, 8'h06, 2'h0}, {1'b1, 8'h08, 2'h0},
    {1'b1, 8'h88, 2'h0}, {1'b1, 8'hc0, 2'h0}, {1'b1, 8'h40, 2'h0},
    {1'b1, 8'h8a, 2'h1}};
  always #25 clk = ~clk;
  sps_suspend_pads uut (.clk(clk), .reset_n(reset_n), .suspend(suspend),
    .config_register_1e(r1e), .config_register_0e(r0e),
    .card_sel_active_high(pol), .tod_clock_in(tod),
    .byte_lane_func_n(fv[1:0]), .card_sel_func_n(fv[3:2]),
    .vsync_func(vs_func), .dma_ack_func_n({fv[1:0], fv[3:2]}),
    .card_buf_func_n(fv[5:4]), .card_dir_func(fv[6]),
    .card_refresh_func_n(fv[1]), .card_attr_func_n(fv[0]),
    .byte_lane_select_n(lane_n), .byte_lane_oe(lane_oe),
    .card_chip_select_n(sel_n), .card_chip_select_oe(sel_oe),
    .card_upper_select_n(up_n), .card_upper_select_oe(up_oe),
    .vsync_first_line(vs), .vsync_first_line_oe(vs_oe),
    .dma_ack_n(ack_n), .dma_ack_oe(ack_oe),
    .card_buffer_enable_n(ena_n), .card_buffer_enable_oe(ena_oe),
    .card_buffer_dir(dir), .card_refresh_n(rfsh_n),
    .card_attr_select_n(attr_n), .card_ctl_oe(ctl_oe), .tod_ticks(ticks));
  sps_far_side far (.clk(clk), .sel_pad(sel_n), .sel_oe(sel_oe),
    .ack_pad(ack_n), .ack_oe(ack_oe), .sel_wire(sel_w), .ack_wire(ack_w));
  task automatic check(input string nm, input logic [7:0] seen,
      input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    for (int i = 0; i < 12; i++) begin
      {suspend, r1e, pol} = rows[i];
      fv = 7'(i * 37 + 5);
      @(negedge clk);
      c = r1e[2:1];
      if (!suspend) begin
        check("lane", {lane_oe, lane_n}, {1'b1, fv[1:0]});
        check("sel", {sel_oe, sel_w}, {1'b1, fv[3:2]});
        check("ack", {ack_oe, ack_n}, {1'b1, fv[1:0], fv[3:2]});
        check("ctl", {ctl_oe, dir, rfsh_n, attr_n},
          {1'b1, fv[6], fv[1:0]});
        check("ena_oe", ena_oe, r1e[7]);
      end else begin
        check("lane_oe", lane_oe, !r1e[3]);
        if (!r1e[3]) check("lane", lane_n, 2'h3);
        check("sel_oe", sel_oe, c != 2'h3);
        if (c != 2'h3) check("sel", sel_w, c == 2'h0 ? 2'h0 :
          c == 2'h1 ? 2'h3 : {~pol});
        check("up_oe", up_oe, !r1e[2]);
        if (!r1e[2]) check("up", up_n, !pol[1]);
        check("ack", {ack_oe, ack_w}, 5'h00);
        check("ena_oe", ena_oe, r1e[7:6] == 2'h2);
        check("ctl_oe", ctl_oe, r1e[7] || !r1e[3]);
        if (r1e[7]) check("ctl", {dir, rfsh_n, attr_n}, 3'h0);
        if (!r1e[7] && !r1e[3])
          check("ctl_in", {rfsh_n, attr_n}, 2'h3);
      end
      if (ena_oe === 1'b1) check("ena", ena_n, fv[5:4]);
    end
    $display("mode table done");
    {suspend, r1e, r0e, vs_func} = {1'b0, 8'h00, 8'h00, 1'b1};
    @(negedge clk);
    check("vs_run", {vs_oe, vs}, 2'h3);
    {suspend, vs_func} = 2'b10;
    repeat (4) @(negedge clk);
    check("vs", {vs_oe, vs}, 2'h3);
    r0e = 8'h01;
    repeat (2) @(negedge clk);
    check("vs_oe", vs_oe, 1'b0);
    $display("vsync done");
    n = ticks;
    // Slow pin edges so the synchroniser sees every level
    repeat (5) begin
      tod = 1'b1;
      repeat (4) @(negedge clk);
      tod = 1'b0;
      repeat (4) @(negedge clk);
    end
    check("tod", 8'(ticks - n), 8'h05);
    $display("tod done");
    reset_n = 1'b0;
    repeat (2) @(negedge clk);
    check("rst", {lane_oe, ack_oe, ctl_oe, sel_oe, ticks[3:0]}, 8'h00);
    $display("reset done");
    // Second release while still in suspend with vsync released
    reset_n = 1'b1;
    @(negedge clk);
    check("rel", {ack_oe, vs_oe, lane_oe, lane_n}, 8'h07);
    $display("release done");
    report_and_stop();
  end
endmodule // sps_suspend_pads_test
